// ### hdl/rcu_cfg.svh
/*
 * constants of the register calculation unit: operation codes, register
 * numbers, command word fields and the read-only register map.
 * assumes: included by bare name from the package and the design.
 */
`ifndef RCU_CFG_SVH
`define RCU_CFG_SVH

// ****************************************************
// data path shape
// ****************************************************
`define RCU_DATA_W 32
`define RCU_HALF_W 16
`define RCU_NREG 32
`define RCU_IDX_W 5
`define RCU_ACC_IDX 5'h0a
// registers up to and including this number are read only (contents fixed at reset)
`define RCU_RO_LAST 5'h03
`define RCU_DIV_MAX 16'h7fff

// ****************************************************
// packed parameter word: op code upper byte, register lower byte
// ****************************************************
`define RCU_OP_MSB 15
`define RCU_OP_LSB 8
`define RCU_REG_MSB 7
`define RCU_REG_LSB 0

// ****************************************************
// operation codes
// ****************************************************
`define RCU_OP_CLEAR 8'h00
`define RCU_OP_ADD 8'h01
`define RCU_OP_SUB 8'h02
`define RCU_OP_LOAD 8'h03
`define RCU_OP_INC 8'h04
`define RCU_OP_DEC 8'h05
`define RCU_OP_ABS 8'h06
`define RCU_OP_STORE 8'h08
`define RCU_OP_LDHI 8'h09
`define RCU_OP_LDLO 8'h0a
`define RCU_OP_AND 8'h0b
`define RCU_OP_OR 8'h0c
`define RCU_OP_XOR 8'h0d
`define RCU_OP_DIV 8'h0e
`define RCU_OP_MULU 8'h0f
`define RCU_OP_MULS 8'h10
`define RCU_OP_WRHI 8'h14
`define RCU_OP_WRLO 8'h15
`define RCU_OP_SHL 8'h16
`define RCU_OP_SAR 8'h17
`define RCU_OP_SHR 8'h18
`define RCU_OP_REM 8'h19

// division takes one cycle per quotient bit
`define RCU_DIV_STEPS 6'h20
`endif

// ### hdl/rcu_pkg.sv
/*
 * types of the register calculation unit.
 * assumes: rcu_cfg.svh is on the include path.
 */
`include "rcu_cfg.svh"
package rcu_pkg;
	// command: packed form, or split form with op and register apart
	typedef struct packed {
		logic valid;
		logic split;
		logic [15:0] word1;
		logic [15:0] word2;
	} rcu_cmd_s;

	// host side direct register access
	typedef struct packed {
		logic wr;
		logic [`RCU_IDX_W-1:0] idx;
		logic [`RCU_DATA_W-1:0] data;
	} rcu_host_s;

	// status conditions of the last calculation
	typedef struct packed {
		logic zero;
		logic pos;
		logic neg;
	} rcu_stat_s;

	typedef enum logic [1:0] {RCU_IDLE, RCU_DIVIDE, RCU_WRITE} rcu_state_e;
endpackage

// ### hdl/rcu_core.sv
/*
 * register calculation unit: 32 data registers, register 10 as accumulator,
 * arithmetic, logic, shift, half-word, multiply, divide and remainder.
 * assumes: commands and host accesses come from logic on clk; one command
 * at a time, accepted while cmd_ready is high.
 */
// Summary of operation
// - two-operand ops use accumulator and chosen register
// - two-operand results go to accumulator
// - single-operand ops read/write chosen register; load and the half-word loads write accumulator
// - register 10 may be the chosen register
// - multiply keeps low 32 product bits
// - signed 32 by positive 16 division, signed quotient
// - remainder uses same operands, never negative
// - writes to read-only registers are dropped
// - every calculation updates zero/positive/negative status
// - 32-bit registers, host and internal access
// - half-word writes preserve the other half; half-word loads sign-extend
// - codes 0-6 and 8 decoded as listed
// - codes 11-13 are and, or, xor
// - codes 22-24 shift left, arithmetic, logical right
// - codes 9,10 load halves; 20,21 write halves
`timescale 1ns/1ps
`include "rcu_cfg.svh"
module rcu_core (
	input wire logic clk, // 25 MHz device clock
	input wire logic sys_rst, // synchronous reset, active high
	input wire rcu_pkg::rcu_cmd_s cmd, // calculation command
	output logic cmd_ready, // command accepted when high
	input wire rcu_pkg::rcu_host_s host, // host register write / read index
	output logic [`RCU_DATA_W-1:0] host_rdata, // registered read of host.idx
	output rcu_pkg::rcu_stat_s status, // status conditions
	output logic done // one-cycle pulse at end of a command
);
	// ****************************************************
	// functions
	// ****************************************************
	// read-only registers take no writes
	function automatic logic writable(input logic [`RCU_IDX_W-1:0] i);
		writable = (i > `RCU_RO_LAST);
	endfunction

	function automatic logic [`RCU_DATA_W-1:0] sext16(input logic [`RCU_HALF_W-1:0] h);
		sext16 = {{`RCU_HALF_W{h[`RCU_HALF_W-1]}}, h};
	endfunction

	// ****************************************************
	// state
	// ****************************************************
	logic [`RCU_DATA_W-1:0] regs_reg [`RCU_NREG];
	logic [`RCU_DATA_W-1:0] regs_next [`RCU_NREG];
	rcu_pkg::rcu_state_e state_reg, state_next;
	rcu_pkg::rcu_stat_s stat_reg, stat_next;
	logic [`RCU_DATA_W-1:0] res_reg, res_next;
	logic [`RCU_IDX_W-1:0] dst_reg, dst_next;
	logic [31:0] quo_reg, quo_next; // magnitude of dividend shifting to quotient
	logic [16:0] rem_reg, rem_next;
	logic [14:0] dvs_reg, dvs_next;
	logic neg_reg, neg_next; // dividend sign
	logic is_rem_reg, is_rem_next;
	logic [5:0] cnt_reg, cnt_next;
	logic done_reg, done_next;
	logic [`RCU_DATA_W-1:0] rdata_reg, rdata_next;

	// command decode
	logic [7:0] op;
	logic [`RCU_IDX_W-1:0] sel;
	logic [`RCU_DATA_W-1:0] acc, rv;
	logic [63:0] prod_u;
	logic signed [63:0] prod_s;

	// split form carries op in word1 and register in word2
	always_comb begin
		op = cmd.split ? cmd.word1[7:0] : cmd.word1[`RCU_OP_MSB:`RCU_OP_LSB];
		sel = cmd.split ? cmd.word2[`RCU_IDX_W-1:0] : cmd.word1[`RCU_IDX_W-1:`RCU_REG_LSB];
		acc = regs_reg[`RCU_ACC_IDX];
		rv = regs_reg[sel];
		prod_u = {32'h0, acc} * {32'h0, rv};
		prod_s = $signed({{32{acc[31]}}, acc}) * $signed({{32{rv[31]}}, rv});
	end

	assign cmd_ready = (state_reg == rcu_pkg::RCU_IDLE);

	// ****************************************************
	// next-state logic
	// ****************************************************
	always_comb begin
		logic [`RCU_DATA_W-1:0] r;
		logic [`RCU_IDX_W-1:0] d;
		logic hit;
		logic [16:0] trial;
		logic [31:0] mag;
		r = '0;
		d = `RCU_ACC_IDX;
		hit = 1'b1;
		trial = '0;
		mag = '0;
		for (int i = 0; i < `RCU_NREG; i++) begin
			regs_next[i] = regs_reg[i];
		end
		state_next = state_reg;
		stat_next = stat_reg;
		res_next = res_reg;
		dst_next = dst_reg;
		quo_next = quo_reg;
		rem_next = rem_reg;
		dvs_next = dvs_reg;
		neg_next = neg_reg;
		is_rem_next = is_rem_reg;
		cnt_next = cnt_reg;
		done_next = 1'b0;
		// host write applies in every state except RCU_WRITE, the result write cycle, even when that cycle writes nothing
		if (host.wr && writable(host.idx) && state_reg != rcu_pkg::RCU_WRITE) begin
			regs_next[host.idx] = host.data;
		end
		rdata_next = regs_reg[host.idx];
		case (state_reg)
			rcu_pkg::RCU_IDLE: begin
				if (cmd.valid) begin
					case (op)
						`RCU_OP_CLEAR: begin r = '0; d = sel; end
						`RCU_OP_ADD: r = acc + rv;
						`RCU_OP_SUB: r = acc - rv;
						`RCU_OP_LOAD: r = rv;
						`RCU_OP_INC: begin r = rv + 32'h1; d = sel; end
						`RCU_OP_DEC: begin r = rv - 32'h1; d = sel; end
						`RCU_OP_ABS: begin r = rv[31] ? (32'h0 - rv) : rv; d = sel; end
						`RCU_OP_STORE: begin r = acc; d = sel; end
						`RCU_OP_LDHI: r = sext16(rv[31:16]);
						`RCU_OP_LDLO: r = sext16(rv[15:0]);
						`RCU_OP_AND: r = acc & rv;
						`RCU_OP_OR: r = acc | rv;
						`RCU_OP_XOR: r = acc ^ rv;
						`RCU_OP_MULU: r = prod_u[31:0];
						`RCU_OP_MULS: r = prod_s[31:0];
						`RCU_OP_WRHI: begin r = {acc[15:0], rv[15:0]}; d = sel; end
						`RCU_OP_WRLO: begin r = {rv[31:16], acc[15:0]}; d = sel; end
						`RCU_OP_SHL: begin r = {rv[30:0], 1'b0}; d = sel; end
						`RCU_OP_SAR: begin r = {rv[31], rv[31:1]}; d = sel; end
						`RCU_OP_SHR: begin r = {1'b0, rv[31:1]}; d = sel; end
						`RCU_OP_DIV, `RCU_OP_REM: hit = 1'b0;
						default: hit = 1'b0;
					endcase
					if (op == `RCU_OP_DIV || op == `RCU_OP_REM) begin
						// divisor is the low word, kept to 15 bits (max 32767)
						mag = acc[31] ? (32'h0 - acc) : acc;
						quo_next = mag;
						rem_next = '0;
						dvs_next = rv[14:0];
						neg_next = acc[31];
						is_rem_next = (op == `RCU_OP_REM);
						cnt_next = `RCU_DIV_STEPS;
						state_next = rcu_pkg::RCU_DIVIDE;
					end else if (hit) begin
						res_next = r;
						dst_next = d;
						state_next = rcu_pkg::RCU_WRITE;
					end else begin
						done_next = 1'b1; // unknown op: consumed, no effect
					end
				end
			end
			rcu_pkg::RCU_DIVIDE: begin
				// restoring division, one quotient bit per cycle
				trial = {rem_reg[15:0], quo_reg[31]};
				if (trial >= {2'b00, dvs_reg}) begin
					rem_next = trial - {2'b00, dvs_reg};
					quo_next = {quo_reg[30:0], 1'b1};
				end else begin
					rem_next = trial;
					quo_next = {quo_reg[30:0], 1'b0};
				end
				cnt_next = cnt_reg - 6'h1;
				if (cnt_reg == 6'h1) begin
					dst_next = `RCU_ACC_IDX;
					state_next = rcu_pkg::RCU_WRITE;
					if (is_rem_next) begin
						// floor-style remainder so it is never negative
						if (neg_reg && rem_next != 17'h0) begin
							res_next = {16'h0, dvs_reg - rem_next[15:0]};
						end else begin
							res_next = {15'h0, rem_next};
						end
					end else begin
						res_next = neg_reg ? (32'h0 - quo_next) : quo_next;
					end
				end
			end
			rcu_pkg::RCU_WRITE: begin
				if (writable(dst_reg)) begin
					regs_next[dst_reg] = res_reg;
				end
				// status follows the computed result
				stat_next.zero = (res_reg == 32'h0);
				stat_next.neg = res_reg[31];
				stat_next.pos = (res_reg != 32'h0) && !res_reg[31];
				done_next = 1'b1;
				state_next = rcu_pkg::RCU_IDLE;
			end
			default: state_next = rcu_pkg::RCU_IDLE;
		endcase
	end

	// ****************************************************
	// registers
	// ****************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < `RCU_NREG; i++) begin
				regs_reg[i] <= '0;
			end
			state_reg <= rcu_pkg::RCU_IDLE;
			stat_reg <= 3'b100;
			res_reg <= '0;
			dst_reg <= '0;
			quo_reg <= '0;
			rem_reg <= '0;
			dvs_reg <= '0;
			neg_reg <= 1'b0;
			is_rem_reg <= 1'b0;
			cnt_reg <= '0;
			done_reg <= 1'b0;
			rdata_reg <= '0;
		end else begin
			regs_reg <= regs_next;
			state_reg <= state_next;
			stat_reg <= stat_next;
			res_reg <= res_next;
			dst_reg <= dst_next;
			quo_reg <= quo_next;
			rem_reg <= rem_next;
			dvs_reg <= dvs_next;
			neg_reg <= neg_next;
			is_rem_reg <= is_rem_next;
			cnt_reg <= cnt_next;
			done_reg <= done_next;
			rdata_reg <= rdata_next;
		end
	end

	assign status = stat_reg;
	assign done = done_reg;
	assign host_rdata = rdata_reg;

	// ****************************************************
	// assertions
	// ****************************************************
	AST_ADD: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_ready && cmd.valid && op == `RCU_OP_ADD) |=> (res_reg == $past(acc + rv)))
		else $error("add result wrong");
	AST_ACC_DST: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_ready && cmd.valid && (op == `RCU_OP_AND || op == `RCU_OP_SUB))
		|=> (dst_reg == `RCU_ACC_IDX))
		else $error("two-operand result not to accumulator");
	AST_SINGLE: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_ready && cmd.valid && op == `RCU_OP_INC) |=> (dst_reg == $past(sel)))
		else $error("single operand destination wrong");
	AST_MUL: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_ready && cmd.valid && op == `RCU_OP_MULU) |=> (res_reg == $past(prod_u[31:0])))
		else $error("multiply low word wrong");
	AST_DIV_TIME: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_ready && cmd.valid && op == `RCU_OP_DIV) |-> ##33 (state_reg == rcu_pkg::RCU_WRITE))
		else $error("division length wrong");
	AST_REM_POS: assert property (@(posedge clk) disable iff (sys_rst)
		(state_reg == rcu_pkg::RCU_WRITE && is_rem_reg && dst_reg == `RCU_ACC_IDX
		&& $past(state_reg) == rcu_pkg::RCU_DIVIDE) |-> !res_reg[31])
		else $error("negative remainder");
	AST_RO: assert property (@(posedge clk) disable iff (sys_rst)
		(state_reg == rcu_pkg::RCU_WRITE && !writable(dst_reg))
		|=> $stable(regs_reg[dst_reg]))
		else $error("read-only register written");
	AST_STAT: assert property (@(posedge clk) disable iff (sys_rst)
		(state_reg == rcu_pkg::RCU_WRITE) |=> (status.zero == ($past(res_reg) == 32'h0)) && done)
		else $error("status not updated");
	AST_UNKNOWN: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_ready && cmd.valid && op == 8'h07 && !host.wr) |=> ($stable(status) && cmd_ready))
		else $error("unknown op had effect");

	// per-operation result checks, destination too except sar and ldlo; host write check
	AST_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_ready && cmd.valid && op == `RCU_OP_CLEAR)
		|=> (res_reg == 32'h0 && dst_reg == $past(sel)))
		else $error("clear result wrong");
	AST_DEC: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_ready && cmd.valid && op == `RCU_OP_DEC)
		|=> (res_reg == $past(rv) - 32'h1 && dst_reg == $past(sel)))
		else $error("decrement result wrong");
	AST_XOR: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_ready && cmd.valid && op == `RCU_OP_XOR)
		|=> (res_reg == ($past(acc) ^ $past(rv)) && dst_reg == `RCU_ACC_IDX))
		else $error("xor result wrong");
	AST_SAR: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_ready && cmd.valid && op == `RCU_OP_SAR)
		|=> (res_reg == {$past(rv[31]), $past(rv[31:1])}))
		else $error("arithmetic right shift wrong");
	AST_LDLO: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_ready && cmd.valid && op == `RCU_OP_LDLO)
		|=> (res_reg == {{16{$past(rv[15])}}, $past(rv[15:0])}))
		else $error("low half load wrong");
	AST_WRHI: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_ready && cmd.valid && op == `RCU_OP_WRHI)
		|=> (res_reg == {$past(acc[15:0]), $past(rv[15:0])} && dst_reg == $past(sel)))
		else $error("high half write wrong");
	AST_HOST: assert property (@(posedge clk) disable iff (sys_rst)
		(host.wr && writable(host.idx) && state_reg != rcu_pkg::RCU_WRITE)
		|=> (regs_reg[$past(host.idx)] == $past(host.data)))
		else $error("host write lost");
endmodule

// ### verif/rcu_issuer.sv
/*
 * command issuer model for the register calculation unit.
 * assumes: driven from tb by task send; unit samples cmd on rising clk.
 */
`timescale 1ns/1ps
module rcu_issuer (
	input wire logic clk, // device clock
	input wire logic cmd_ready, // unit can take a command
	output rcu_pkg::rcu_cmd_s cmd // command toward the unit
);
	// idle until the first command
	initial begin
		cmd = '0;
	end

	// present one command at a falling edge, hold it until the take edge
	task automatic send(input logic [7:0] op, input logic [7:0] idx, input logic split,
		output logic ok);
		int n;
		@(negedge clk);
		cmd.valid = 1'b1;
		cmd.split = split;
		if (split) begin // two word form
			cmd.word1 = {8'h00, op};
			cmd.word2 = {8'h00, idx};
		end else begin // packed form, op in upper byte
			cmd.word1 = {op, idx};
			cmd.word2 = ~cmd.word2;
		end
		n = 0;
		while (cmd_ready !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		ok = (n < 100);
		@(posedge clk);
		@(negedge clk);
		cmd.valid = 1'b0;
		cmd.word1 = ~cmd.word1; // released words must not keep their value
		cmd.word2 = ~cmd.word2;
	endtask
endmodule

// ### verif/tb.sv
/*
 * self-checking bench of the register calculation unit.
 * assumes: rcu_cfg.svh on the include path, rcu_issuer compiled before.
 */
`timescale 1ns/1ps
`include "rcu_cfg.svh"
module tb;
	logic clk;
	logic sys_rst;
	logic cmd_ready;
	logic done;
	logic [31:0] host_rdata;
	rcu_pkg::rcu_cmd_s cmd;
	rcu_pkg::rcu_host_s host;
	rcu_pkg::rcu_stat_s status;
	int miscompares;
	int checked;

	rcu_issuer i_iss (.clk(clk), .cmd_ready(cmd_ready), .cmd(cmd));
	rcu_core i_dut (.clk(clk), .sys_rst(sys_rst), .cmd(cmd), .cmd_ready(cmd_ready),
		.host(host), .host_rdata(host_rdata), .status(status), .done(done));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ****************************************************
	// shared tasks
	// ****************************************************
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_st(input rcu_pkg::rcu_stat_s got, input rcu_pkg::rcu_stat_s exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic host_wr(input logic [4:0] idx, input logic [31:0] data);
		@(negedge clk);
		host.wr = 1'b1;
		host.idx = idx;
		host.data = data;
		@(negedge clk);
		host.wr = 1'b0;
	endtask

	task automatic host_rd(input logic [4:0] idx, output logic [31:0] data);
		@(negedge clk);
		host.idx = idx;
		@(negedge clk);
		data = host_rdata;
	endtask

	// issue one command and wait for its done pulse
	task automatic calc(input logic [7:0] op, input logic [4:0] idx, input logic split);
		logic ok;
		int n;
		i_iss.send(op, {3'h0, idx}, split, ok);
		n = 0;
		while (done !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		if (!ok || n >= 100) begin
			miscompares++;
			report_and_stop();
		end
	endtask

	// load acc and register 20, run op on register i, check register d and status
	task automatic t(input logic [7:0] op, input logic s, input logic [31:0] a,
		input logic [4:0] i, input logic [31:0] r, input logic [4:0] d, input logic [31:0] e);
		logic [31:0] got;
		host_wr(5'h14, r);
		host_wr(5'h0a, a);
		calc(op, i, s);
		cmp_st(status, {e == 32'h0, !e[31] && e != 32'h0, e[31]});
		host_rd(d, got);
		cmp(got, e);
	endtask

	// ****************************************************
	// scenarios
	// ****************************************************
	task automatic sc_reset();
		logic [31:0] got;
		host_rd(5'h05, got);
		cmp(got, 32'h0);
		cmp_st(status, 3'h4);
		host_wr(5'h1f, 32'hdeadbeef);
		host_rd(5'h1f, got);
		cmp(got, 32'hdeadbeef);
	endtask

	task automatic sc_arith();
		logic [31:0] got;
		t(`RCU_OP_ADD, 0, 32'h5, 5'h14, 32'hfffffffd, 5'h0a, 32'h2);
		t(`RCU_OP_SUB, 1, 32'h5, 5'h14, 32'h7, 5'h0a, 32'hfffffffe);
		t(`RCU_OP_LOAD, 0, 32'h9, 5'h14, 32'h1234, 5'h0a, 32'h1234);
		t(`RCU_OP_CLEAR, 0, 32'h9, 5'h14, 32'h55, 5'h14, 32'h0);
		t(`RCU_OP_INC, 0, 32'h9, 5'h14, 32'hffffffff, 5'h14, 32'h0);
		host_rd(5'h0a, got);
		cmp(got, 32'h9);
		t(`RCU_OP_DEC, 0, 32'h9, 5'h14, 32'h0, 5'h14, 32'hffffffff);
		t(`RCU_OP_ABS, 1, 32'h9, 5'h14, 32'hfffffff9, 5'h14, 32'h7);
		t(`RCU_OP_STORE, 0, 32'h77, 5'h14, 32'h1, 5'h14, 32'h77);
	endtask

	task automatic sc_logic_shift();
		t(`RCU_OP_AND, 0, 32'hf0f01234, 5'h14, 32'hff00ff00, 5'h0a, 32'hf0001200);
		t(`RCU_OP_OR, 1, 32'hf0f01234, 5'h14, 32'hff00ff00, 5'h0a, 32'hfff0ff34);
		t(`RCU_OP_XOR, 0, 32'hf0f01234, 5'h14, 32'hff00ff00, 5'h0a, 32'h0ff0ed34);
		t(`RCU_OP_SHL, 0, 32'h0, 5'h14, 32'hc0000001, 5'h14, 32'h80000002);
		t(`RCU_OP_SAR, 0, 32'h0, 5'h14, 32'h80000002, 5'h14, 32'hc0000001);
		t(`RCU_OP_SHR, 0, 32'h0, 5'h14, 32'h80000002, 5'h14, 32'h40000001);
	endtask

	task automatic sc_half();
		t(`RCU_OP_LDHI, 0, 32'h0, 5'h14, 32'h80011234, 5'h0a, 32'hffff8001);
		t(`RCU_OP_LDLO, 0, 32'h0, 5'h14, 32'h12348000, 5'h0a, 32'hffff8000);
		t(`RCU_OP_WRHI, 0, 32'habcd, 5'h14, 32'h11112222, 5'h14, 32'habcd2222);
		t(`RCU_OP_WRLO, 0, 32'habcd, 5'h14, 32'h11112222, 5'h14, 32'h1111abcd);
	endtask

	task automatic sc_muldiv();
		t(`RCU_OP_MULU, 0, 32'h10003, 5'h14, 32'h10002, 5'h0a, 32'h50006);
		t(`RCU_OP_MULS, 0, 32'hfffffffd, 5'h14, 32'h7, 5'h0a, 32'hffffffeb);
		t(`RCU_OP_DIV, 0, 32'hffffff9c, 5'h14, 32'h12340007, 5'h0a, 32'hfffffff2);
		t(`RCU_OP_DIV, 0, 32'h17ffe, 5'h14, 32'h7fff, 5'h0a, 32'h3);
		t(`RCU_OP_REM, 0, 32'hffffff9c, 5'h14, 32'h7, 5'h0a, 32'h5);
		t(`RCU_OP_REM, 0, 32'h17ffe, 5'h14, 32'h7fff, 5'h0a, 32'h1);
	endtask

	task automatic sc_acc_ro();
		logic [31:0] got;
		t(`RCU_OP_ADD, 0, 32'h6, 5'h0a, 32'h1, 5'h0a, 32'hc);
		t(`RCU_OP_ADD, 0, 32'h5, 5'h02, 32'h1, 5'h0a, 32'h5);
		host_wr(5'h02, 32'h99);
		calc(`RCU_OP_STORE, 5'h02, 1'b0);
		host_rd(5'h02, got);
		cmp(got, 32'h0);
	endtask

	task automatic sc_unknown_b2b();
		logic [31:0] got;
		logic ok;
		t(`RCU_OP_ADD, 0, 32'h5, 5'h14, 32'hfffffffd, 5'h0a, 32'h2);
		calc(8'h07, 5'h14, 1'b0);
		cmp_st(status, 3'h2);
		host_rd(5'h0a, got);
		cmp(got, 32'h2);
		host_wr(5'h14, 32'ha);
		i_iss.send(`RCU_OP_INC, 8'h14, 1'b0, ok);
		cmp({31'h0, ok}, 32'h1);
		calc(`RCU_OP_INC, 5'h14, 1'b1);
		host_rd(5'h14, got);
		cmp(got, 32'hc);
	endtask

	// reset in mid-run clears registers and status
	task automatic sc_mid_reset();
		logic [31:0] got;
		host_wr(5'h1f, 32'h5a5a5a5a);
		@(negedge clk);
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		host_rd(5'h1f, got);
		cmp(got, 32'h0);
		cmp_st(status, 3'h4);
	endtask

	// ****************************************************
	// main sequence
	// ****************************************************
	initial begin
		sys_rst = 1'b1;
		host = '0;
		miscompares = 0;
		checked = 0;
		repeat (16) @(negedge clk);
		sys_rst = 1'b0;
		sc_reset();
		sc_arith();
		sc_logic_shift();
		sc_half();
		sc_muldiv();
		sc_acc_ro();
		sc_unknown_b2b();
		sc_mid_reset();
		report_and_stop();
	end
endmodule
